// file: src/tks_params.svh
// register map, reset values, field positions and timing constants
`ifndef TKS_PARAMS_SVH
`define TKS_PARAMS_SVH
// register offsets
`define TKS_OFF_ID_LO    8'h00
`define TKS_OFF_ID_HI    8'h01
`define TKS_OFF_REV      8'h02
`define TKS_OFF_PWR      8'h03
`define TKS_OFF_CLKG     8'h04
`define TKS_OFF_ICTL     8'h08
`define TKS_OFF_IEN      8'h09
`define TKS_OFF_ISTS     8'h0A
`define TKS_OFF_PIEN_LO  8'h0B
`define TKS_OFF_PIEN_HI  8'h0C
`define TKS_OFF_PIST_LO  8'h0D
`define TKS_OFF_PIST_HI  8'h0E
`define TKS_OFF_MON      8'h10
`define TKS_OFF_OUT      8'h12
`define TKS_OFF_DIR      8'h14
`define TKS_OFF_FUNC     8'h16
// reset values
`define TKS_RST_CLKG     8'hEF
`define TKS_RST_ICTL     8'h01
`define TKS_RST_IEN      8'h01
`define TKS_RST_ISTS     8'h01
`define TKS_RST_ZERO     8'h00
// power and reset control fields
`define TKS_B_SLEEP      3
`define TKS_B_WARM       2
`define TKS_B_SOFT       1
`define TKS_B_HIB        0
// clock gating fields
`define TKS_B_CG_GPIO    2
`define TKS_B_CG_FIFO    1
`define TKS_B_CG_TOUCH   0
`define TKS_B_SCLK_HI    7
`define TKS_B_SCLK_LO    5
// interrupt control fields
`define TKS_B_POL        2
`define TKS_B_TYPE       1
`define TKS_B_GLOB_EN    0
// interrupt source fields
`define TKS_B_SRC_GPIO   7
`define TKS_B_SRC_SYS    2
`define TKS_B_SRC_FIFO   1
`define TKS_B_SRC_POR    0
`define TKS_SRC_MASK     8'h87
// pins and bus
`define TKS_PINS         3
`define TKS_I2C_ADDR     7'h58
`define TKS_BYTE_BITS    4'h8
// interrupt pulse timing
`define TKS_IRQ_PULSE_NS 200
`define TKS_CLK_NS       20
`endif

// file: src/tks_pkg.sv
// types shared by the touch key system block
package tks_pkg;
  // serial slave sequencer states
  typedef enum logic [2:0] {
    TKS_IDLE, TKS_ADDR, TKS_ACK, TKS_WR, TKS_RD, TKS_RACK
  } tks_i2c_st_t;
  typedef logic [7:0] tks_byte_t;
endpackage : tks_pkg

// file: src/tks_sync.sv
// two flip-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ps
`default_nettype none
module tks_sync #(
  parameter int          W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // pin side and synchronised side
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : tks_sync
`default_nettype wire

// file: src/tks_sys_regs.sv
// system control, interrupt and pin control registers behind a serial slave
`timescale 1ns/1ps
`default_nettype none
`include "tks_params.svh"

// Function
// - sleep request bit starts sleep entry, clears when sleep is entered
// - warm reset restarts state machines, register contents stay
// - full reset returns all registers to reset values and restarts machines
// - hibernate request bit forces hibernation, clears once entered
// - clock gating bits 2,1,0 stop pin, fifo and touch unit clocks
// - sensor clock field divides by 1,2,4,8 or 16 for 1xx
// - polarity zero pulls interrupt pin low, one drives it high
// - trigger type zero gives level, one gives a 200 ns pulse
// - global enable zero blocks all interrupts from the pin
// - per-source enables steer the pin, status records every event
// - writing one clears a status bit, zero leaves it
// - per-pin enable lets level transitions raise the pin interrupt
// - pin status updates regardless of enables, write one clears
// - monitor read gives present pin levels, writes ignored
// - output state bit drives its pin high or low
// - direction zero is input, one output, all zero after reset
// - function bit one selects general purpose, zero touch key
// - sleep or hibernate requests wait while a key is held
module tks_sys_regs #(
  parameter tks_pkg::tks_byte_t ID_LO = 8'h5A, // arbitrary value
  parameter tks_pkg::tks_byte_t ID_HI = 8'hC3, // arbitrary value
  parameter tks_pkg::tks_byte_t REV   = 8'h11  // arbitrary value
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // serial register port pins
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output var  logic                 sda_o,
  output var  logic                 sda_oe_n,
  // interrupt pin
  output var  logic                 irq_o,
  output var  logic                 irq_oe_n,
  // general purpose pins
  input  wire logic [`TKS_PINS-1:0] gpio_i,
  output var  logic [`TKS_PINS-1:0] gpio_o,
  output var  logic [`TKS_PINS-1:0] gpio_oe_n,
  output var  logic [`TKS_PINS-1:0] touch_sel,
  // power manager
  input  wire logic                 touch_held,
  input  wire logic                 sleep_ack,
  input  wire logic                 hib_ack,
  output var  logic                 sleep_req,
  output var  logic                 hib_req,
  output var  logic                 warm_rst,
  output var  logic                 soft_rst,
  // unit clocks and sensor rate
  input  wire logic                 sensor_src_tick,
  output var  logic                 sensor_tick,
  output var  logic                 gpio_clk_off,
  output var  logic                 fifo_clk_off,
  output var  logic                 touch_clk_off,
  // event sources
  input  wire logic                 fifo_not_empty,
  input  wire logic                 sys_event
);
  import tks_pkg::*;

  localparam int PULSE_CYC = `TKS_IRQ_PULSE_NS / `TKS_CLK_NS;
  localparam logic [3:0] PULSE_LD = 4'(PULSE_CYC);
  localparam int NP = `TKS_PINS;

  tks_i2c_st_t    st_r;
  logic [3:0]     bit_r;
  tks_byte_t      shf_r, ptr_r, wr_addr_r, wr_data_r;
  logic           rw_r, ptr_set_r, wr_stb_r;
  logic           scl_d_r, sda_d_r;
  logic           sleep_r, hib_r, soft_r, warm_r;
  tks_byte_t      clkg_r, ictl_r, ien_r, ists_r;
  logic [NP-1:0]  pien_r, pist_r, out_r, dir_r, func_r, pin_d_r;
  logic [3:0]     div_cnt_r, pcnt_r;
  logic           pend_d_r;
  logic [1:0]     bus_q;
  logic [NP-1:0]  pin_q;

  // pins enter through two flops before anything reads them
  tks_sync #(.W(2), .INIT(2'h3)) u_sync_bus (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({scl_i, sda_i}),
    .q       (bus_q)
  );
  tks_sync #(.W(NP), .INIT('0)) u_sync_pin (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (gpio_i),
    .q       (pin_q)
  );

  // bus conditions from the synchronised lines
  wire scl   = bus_q[1];
  wire sda   = bus_q[0];
  wire start = scl && scl_d_r && sda_d_r && !sda;
  wire stop  = scl && scl_d_r && !sda_d_r && sda;
  wire rise  = scl && !scl_d_r;
  wire fall  = !scl && scl_d_r;
  wire full  = (bit_r == `TKS_BYTE_BITS);
  wire hit   = (shf_r[7:1] == `TKS_I2C_ADDR);
  wire fsm_rst = !rst_n || soft_r || warm_r;
  wire reg_rst = !rst_n || soft_r;

  // read data selection; reserved bits read zero
  wire [7:0] pad = `TKS_RST_ZERO;
  wire tks_byte_t rd_data =
    (ptr_r == `TKS_OFF_ID_LO)   ? ID_LO :
    (ptr_r == `TKS_OFF_ID_HI)   ? ID_HI :
    (ptr_r == `TKS_OFF_REV)     ? REV :
    (ptr_r == `TKS_OFF_PWR)     ? {pad[7:4], sleep_r, 2'b00, hib_r} :
    (ptr_r == `TKS_OFF_CLKG)    ? clkg_r :
    (ptr_r == `TKS_OFF_ICTL)    ? ictl_r :
    (ptr_r == `TKS_OFF_IEN)     ? ien_r :
    (ptr_r == `TKS_OFF_ISTS)    ? ists_r :
    (ptr_r == `TKS_OFF_PIEN_LO) ? {pad[7:NP], pien_r} :
    (ptr_r == `TKS_OFF_PIST_LO) ? {pad[7:NP], pist_r} :
    (ptr_r == `TKS_OFF_MON)     ? {pad[7:NP], pin_q} :
    (ptr_r == `TKS_OFF_OUT)     ? {pad[7:NP], out_r} :
    (ptr_r == `TKS_OFF_DIR)     ? {pad[7:NP], dir_r} :
    (ptr_r == `TKS_OFF_FUNC)    ? {pad[7:NP], func_r} : pad;

  // serial slave sequencer; pointer advances after every data byte written or read
  always_ff @(posedge clk_sys) begin
    if (fsm_rst) begin
      st_r <= TKS_IDLE;
      bit_r <= '0;
      shf_r <= '0;
      rw_r <= 1'b0;
      ptr_set_r <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_stb_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
    end else begin
      wr_stb_r <= 1'b0;
      if (start) begin
        st_r <= TKS_ADDR;
        bit_r <= '0;
        sda_oe_n <= 1'b1;
      end else if (stop) begin
        st_r <= TKS_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (st_r)
          TKS_ADDR, TKS_WR: begin
            if (rise) begin
              shf_r <= {shf_r[6:0], sda};
              bit_r <= bit_r + 4'h1;
            end else if (fall && full) begin
              bit_r <= '0;
              if (st_r == TKS_ADDR && !hit) begin
                st_r <= TKS_IDLE; // not addressed: stay off the bus
              end else begin
                st_r <= TKS_ACK;
                sda_oe_n <= 1'b0;
                if (st_r == TKS_ADDR) begin
                  rw_r <= shf_r[0];
                  ptr_set_r <= !shf_r[0];
                end else if (ptr_set_r) begin
                  ptr_set_r <= 1'b0;
                end else begin
                  wr_stb_r <= 1'b1;
                  wr_addr_r <= ptr_r;
                  wr_data_r <= shf_r;
                end
              end
            end
          end
          TKS_ACK: begin
            if (fall && rw_r) begin
              shf_r <= rd_data;
              sda_oe_n <= rd_data[7];
              bit_r <= 4'h1;
              st_r <= TKS_RD;
            end else if (fall) begin
              sda_oe_n <= 1'b1;
              st_r <= TKS_WR;
            end
          end
          TKS_RD: begin
            if (fall && full) begin
              sda_oe_n <= 1'b1;
              bit_r <= '0;
              st_r <= TKS_RACK;
            end else if (fall) begin
              sda_oe_n <= shf_r[6];
              shf_r <= {shf_r[6:0], 1'b0};
              bit_r <= bit_r + 4'h1;
            end
          end
          TKS_RACK: begin
            if (rise) begin
              st_r <= sda ? TKS_IDLE : TKS_ACK; // master nack ends the read
            end
          end
          default: st_r <= TKS_IDLE;
        endcase
      end
    end
  end

  // pointer: loaded by the first written byte, stepped after each data byte
  wire ptr_ld  = (st_r == TKS_WR) && fall && full && ptr_set_r && !start && !stop;
  wire ptr_inc = wr_stb_r || ((st_r == TKS_ACK) && fall && rw_r && !start && !stop);
  always_ff @(posedge clk_sys) begin
    if (fsm_rst) begin
      ptr_r <= ptr_r; // pointer is register content, kept by a warm reset
    end else if (ptr_ld) begin
      ptr_r <= shf_r;
    end else if (ptr_inc) begin
      ptr_r <= ptr_r + 8'h01;
    end
    if (!rst_n || soft_r) begin
      ptr_r <= `TKS_RST_ZERO;
    end
  end

  // write decode
  wire [7:0] wd   = wr_data_r;
  wire we_pwr  = wr_stb_r && (wr_addr_r == `TKS_OFF_PWR);
  wire we_clkg = wr_stb_r && (wr_addr_r == `TKS_OFF_CLKG);
  wire we_ictl = wr_stb_r && (wr_addr_r == `TKS_OFF_ICTL);
  wire we_ien  = wr_stb_r && (wr_addr_r == `TKS_OFF_IEN);
  wire we_ists = wr_stb_r && (wr_addr_r == `TKS_OFF_ISTS);
  wire we_pien = wr_stb_r && (wr_addr_r == `TKS_OFF_PIEN_LO);
  wire we_pist = wr_stb_r && (wr_addr_r == `TKS_OFF_PIST_LO);
  wire we_out  = wr_stb_r && (wr_addr_r == `TKS_OFF_OUT);
  wire we_dir  = wr_stb_r && (wr_addr_r == `TKS_OFF_DIR);
  wire we_func = wr_stb_r && (wr_addr_r == `TKS_OFF_FUNC);

  // event sources; a gated unit clock freezes its events
  wire [NP-1:0] chg = (pin_q ^ pin_d_r) & {NP{!clkg_r[`TKS_B_CG_GPIO]}};
  wire gpio_evt = |(chg & pien_r);
  wire fifo_evt = fifo_not_empty && !clkg_r[`TKS_B_CG_FIFO];
  wire [7:0] set_v = {gpio_evt, 4'h0, sys_event, fifo_evt, 1'b0};
  wire [7:0] clr_v = we_ists ? (wd & `TKS_SRC_MASK) : `TKS_RST_ZERO;
  wire [NP-1:0] pclr = we_pist ? wd[NP-1:0] : '0;

  // power and reset requests; hardware clears on entry, host write wins
  always_ff @(posedge clk_sys) begin
    if (reg_rst) begin
      sleep_r <= 1'b0;
      hib_r <= 1'b0;
    end else if (we_pwr) begin
      sleep_r <= wd[`TKS_B_SLEEP];
      hib_r <= wd[`TKS_B_HIB];
    end else begin
      sleep_r <= sleep_r && !sleep_ack;
      hib_r <= hib_r && !hib_ack;
    end
  end

  // self-clearing reset pulses, cleared only by the pin reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      soft_r <= 1'b0;
      warm_r <= 1'b0;
    end else begin
      soft_r <= we_pwr && wd[`TKS_B_SOFT];
      warm_r <= we_pwr && wd[`TKS_B_WARM];
    end
  end

  // configuration and status registers
  always_ff @(posedge clk_sys) begin
    if (reg_rst) begin
      clkg_r <= `TKS_RST_CLKG;
      ictl_r <= `TKS_RST_ICTL;
      ien_r <= `TKS_RST_IEN;
      ists_r <= `TKS_RST_ISTS; // power-on event pending after reset
      pien_r <= '0;
      pist_r <= '0;
      out_r <= '0;
      dir_r <= '0;
      func_r <= '0;
    end else begin
      if (we_clkg) clkg_r <= wd;
      if (we_ictl) ictl_r <= wd & {5'h00, 3'h7};
      if (we_ien) ien_r <= wd & `TKS_SRC_MASK;
      if (we_pien) pien_r <= wd[NP-1:0];
      if (we_out) out_r <= wd[NP-1:0];
      if (we_dir) dir_r <= wd[NP-1:0];
      if (we_func) func_r <= wd[NP-1:0];
      ists_r <= (ists_r & ~clr_v) | set_v;
      pist_r <= (pist_r & ~pclr) | chg;
    end
  end

  // interrupt qualification and pulse stretch
  wire pend = ictl_r[`TKS_B_GLOB_EN] && |(ists_r & ien_r);
  wire pulse_start = pend && !pend_d_r;
  wire irq_act = ictl_r[`TKS_B_GLOB_EN] &&
                 (ictl_r[`TKS_B_TYPE] ? (pcnt_r != 4'h0) : pend);

  // sensor clock divide mask: 1, 2, 4, 8, or 16 for 1xx
  wire [2:0] sclk = clkg_r[`TKS_B_SCLK_HI:`TKS_B_SCLK_LO];
  wire [3:0] dmask = sclk[2] ? 4'hF : 4'((5'h01 << sclk[1:0]) - 5'h01);
  wire s_en = sensor_src_tick && !clkg_r[`TKS_B_CG_TOUCH];

  // timing machines, restarted by warm reset
  always_ff @(posedge clk_sys) begin
    if (fsm_rst) begin
      pin_d_r <= pin_q;
      div_cnt_r <= '0;
      pcnt_r <= '0;
      pend_d_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      pin_d_r <= pin_q;
      scl_d_r <= scl;
      sda_d_r <= sda;
      pend_d_r <= pend;
      if (s_en) div_cnt_r <= div_cnt_r + 4'h1;
      if (pulse_start) pcnt_r <= PULSE_LD;
      else if (pcnt_r != 4'h0) pcnt_r <= pcnt_r - 4'h1;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
      irq_o <= 1'b0;
      irq_oe_n <= 1'b1;
      gpio_o <= '0;
      gpio_oe_n <= '1;
      touch_sel <= '1;
      sleep_req <= 1'b0;
      hib_req <= 1'b0;
      warm_rst <= 1'b0;
      soft_rst <= 1'b0;
      sensor_tick <= 1'b0;
      {gpio_clk_off, fifo_clk_off, touch_clk_off} <= 3'h7;
    end else begin
      sda_o <= 1'b0; // open drain: only the enable moves
      irq_o <= ictl_r[`TKS_B_POL];
      irq_oe_n <= !irq_act;
      gpio_o <= out_r;
      gpio_oe_n <= ~(dir_r & func_r);
      touch_sel <= ~func_r;
      sleep_req <= sleep_r && !touch_held;
      hib_req <= hib_r && !touch_held;
      warm_rst <= warm_r;
      soft_rst <= soft_r;
      sensor_tick <= s_en && ((div_cnt_r & dmask) == dmask);
      gpio_clk_off <= clkg_r[`TKS_B_CG_GPIO];
      fifo_clk_off <= clkg_r[`TKS_B_CG_FIFO];
      touch_clk_off <= clkg_r[`TKS_B_CG_TOUCH];
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sleep_clear_a: assert property (sleep_r && sleep_ack && !we_pwr && !soft_r
    |=> !sleep_r) else $error("sleep bit not cleared");
  hib_clear_a: assert property (hib_r && hib_ack && !we_pwr && !soft_r
    |=> !hib_r) else $error("hibernate bit not cleared");
  warm_keep_a: assert property (warm_r && !soft_r && !we_clkg
    |=> clkg_r == $past(clkg_r)) else $error("warm reset hit register");
  soft_reset_a: assert property (soft_r |=> clkg_r == `TKS_RST_CLKG
    && ists_r[`TKS_B_SRC_POR]) else $error("soft reset incomplete");
  touch_gate_a: assert property (clkg_r[`TKS_B_CG_TOUCH]
    |=> !sensor_tick) else $error("sensor tick while gated");
  irq_level_a: assert property (pend && !ictl_r[`TKS_B_TYPE]
    |=> !irq_oe_n && irq_o == $past(ictl_r[`TKS_B_POL])) else $error("level irq wrong");
  irq_pulse_a: assert property (pulse_start && ictl_r[`TKS_B_TYPE]
    && $stable(ictl_r) |=> ##1 (!irq_oe_n) [*8]) else $error("pulse too short");
  glob_block_a: assert property (!ictl_r[`TKS_B_GLOB_EN]
    |=> irq_oe_n) else $error("irq through disabled gate");
  sys_record_a: assert property (sys_event && !soft_r
    |=> ists_r[`TKS_B_SRC_SYS]) else $error("event not recorded");
  w1c_por_a: assert property (we_ists && wd[`TKS_B_SRC_POR] && !soft_r
    |=> !ists_r[`TKS_B_SRC_POR]) else $error("status not cleared");
  pin_status_a: assert property ((|chg) && !soft_r
    |=> (pist_r & $past(chg)) == $past(chg)) else $error("pin status lost");
  pin_drive_a: assert property (1'b1
    |=> gpio_oe_n == ~$past(dir_r & func_r)) else $error("pin drive wrong");
  held_defer_a: assert property (touch_held
    |=> !sleep_req && !hib_req) else $error("request while key held");

  addr_ack_c: cover property (st_r == TKS_ADDR && fall && full && hit);
  reg_write_c: cover property (we_ictl);
  reg_read_c: cover property (st_r == TKS_RACK && rise);
  irq_pulse_c: cover property (pulse_start && ictl_r[`TKS_B_TYPE]);
endmodule : tks_sys_regs
`default_nettype wire

// file: tb/tks_host_bfm.sv
// serial bus host model for the register port
`timescale 1ns/1ps
`default_nettype none
`include "tks_params.svh"
module tks_host_bfm (
  // clock
  input  wire logic clk_sys,
  // bus lines, data released high by the pull-up
  output var  logic scl,
  output var  logic sda_m,
  input  wire logic sda
);
  logic ack_r;
  int   nak_cnt;
  // lines idle released
  initial begin
    scl     = 1'b1;
    sda_m   = 1'b1;
    ack_r   = 1'b0;
    nak_cnt = 0;
  end
  // quarter bit: four clocks keep each scl half above the pin sync delay
  task automatic q();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : q
  // one bit slot: data set while scl low, sampled mid high
  task automatic bit_slot(input logic v, output logic s);
    sda_m = v;
    q();
    scl = 1'b1;
    q();
    s = sda;
    q();
    scl = 1'b0;
    q();
  endtask : bit_slot
  // start, also used as repeated start
  task automatic start();
    sda_m = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_m = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask : start
  task automatic stop();
    sda_m = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_m = 1'b1;
    q();
  endtask : stop
  // byte out msb first, then ack slot with data released
  task automatic put(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], s);
    end
    bit_slot(1'b1, s);
    ack_r = (s === 1'b0);
    if (!ack_r) nak_cnt++;
  endtask : put
  task automatic wr(input logic [7:0] off, input logic [7:0] v);
    start();
    put({`TKS_I2C_ADDR, 1'b0});
    put(off);
    put(v);
    stop();
  endtask : wr
  // single byte read closed by a nack
  task automatic rd(input logic [7:0] off, output logic [7:0] v);
    logic s;
    start();
    put({`TKS_I2C_ADDR, 1'b0});
    put(off);
    start();
    put({`TKS_I2C_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, v[i]);
    end
    bit_slot(1'b1, s);
    stop();
  endtask : rd
endmodule : tks_host_bfm
`default_nettype wire

// file: tb/touch_key_system_irq_gpio_tb_top.sv
// bench for the system, interrupt and pin control registers
`timescale 1ns/1ps
`default_nettype none
`include "tks_params.svh"
module touch_key_system_irq_gpio_tb_top;
  import tks_pkg::*;
  logic       clk_sys, rst_n, scl, sda_m, sda, sda_o, sda_oe_n, irq_o, irq_oe_n;
  logic [2:0] gpio_in, gpio_o, gpio_oe_n, touch_sel;
  logic       touch_held, sleep_ack, hib_ack, sleep_req, hib_req, warm_rst, soft_rst;
  logic       src_tick, sensor_tick, gpio_off, fifo_off, touch_off, fifo_ne, sys_ev;
  tks_byte_t  d;
  tks_byte_t  m;
  int         failures, n_checks, cyc, n, n_warm, n_soft;
  // offsets and reset values; ids match the arbitrary values set below
  tks_byte_t  offs [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A,
                            8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h12, 8'h14, 8'h16};
  tks_byte_t  rstv [17] = '{8'hA5, 8'h3C, 8'h44, 8'h00, 8'hEF, 8'h00, 8'h01, 8'h01, 8'h01,
                            8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00};
  // open drain data line with pull-up
  assign sda = sda_m & (sda_oe_n | sda_o);
  // identity values are arbitrary
  tks_sys_regs #(.ID_LO(8'hA5), .ID_HI(8'h3C), .REV(8'h44)) tks_sys_regs_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .irq_o(irq_o), .irq_oe_n(irq_oe_n), .gpio_i(gpio_in),
    .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n), .touch_sel(touch_sel),
    .touch_held(touch_held), .sleep_ack(sleep_ack), .hib_ack(hib_ack),
    .sleep_req(sleep_req), .hib_req(hib_req), .warm_rst(warm_rst), .soft_rst(soft_rst),
    .sensor_src_tick(src_tick), .sensor_tick(sensor_tick), .gpio_clk_off(gpio_off),
    .fifo_clk_off(fifo_off), .touch_clk_off(touch_off), .fifo_not_empty(fifo_ne),
    .sys_event(sys_ev));
  tks_host_bfm tks_host_bfm_i (.clk_sys(clk_sys), .scl(scl), .sda_m(sda_m), .sda(sda));
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic tk(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : tk
  task automatic wr(input tks_byte_t off, input tks_byte_t v);
    tks_host_bfm_i.wr(off, v);
    tk(2);
  endtask : wr
  task automatic rchk(input tks_byte_t off, input tks_byte_t exp);
    tks_host_bfm_i.rd(off, d);
    check($sformatf("reg %0h", off), d, exp);
  endtask : rchk
  task automatic pulse_ev();
    sys_ev = 1'b1;
    tk(1);
    sys_ev = 1'b0;
    tk(4);
  endtask : pulse_ev
  // watchdog: the sequence needs about 44000 cycles; reset pulses counted too
  always @(posedge clk_sys) begin
    cyc++;
    n_warm += warm_rst;
    n_soft += soft_rst;
    if (cyc == 70000) begin
      failures++;
      test_done();
    end
  end
  // main sequence
  initial begin
    {rst_n, touch_held, sleep_ack, hib_ack, src_tick, fifo_ne, sys_ev} = 7'h00;
    gpio_in = 3'h5;
    tk(4);
    rst_n = 1'b1;
    tk(4);
    check("irq", {irq_o, irq_oe_n}, 2'h0);
    check("gates", {gpio_off, fifo_off, touch_off}, 3'h7);
    check("pins", {gpio_oe_n, touch_sel}, 6'h3F);
    for (int i = 0; i < 17; i++) rchk(offs[i], rstv[i]);
    $display("test reset finished");
    // status: zero write keeps, one clears; read-only places drop writes
    wr(8'h0A, 8'h00);
    rchk(8'h0A, 8'h01);
    wr(8'h0A, 8'h01);
    rchk(8'h0A, 8'h00);
    check("irq_clr", irq_oe_n, 1'b1);
    wr(8'h00, 8'hFF);
    wr(8'h10, 8'hFF);
    rchk(8'h00, 8'hA5);
    rchk(8'h10, 8'h05);
    $display("test status finished");
    // event recorded while masked, then steered, gated, inverted, pulsed
    pulse_ev();
    rchk(8'h0A, 8'h04);
    check("masked", irq_oe_n, 1'b1);
    wr(8'h09, 8'h04); // reserved bits written as zero
    check("steered", {irq_o, irq_oe_n}, 2'h0);
    wr(8'h08, 8'h00);
    check("gated", irq_oe_n, 1'b1);
    wr(8'h08, 8'h05);
    check("high", {irq_o, irq_oe_n}, 2'h2);
    wr(8'h0A, 8'h04);
    wr(8'h08, 8'h07);
    sys_ev = 1'b1;
    tk(1);
    sys_ev = 1'b0;
    n = 0;
    repeat (30) begin
      tk(1);
      if (irq_oe_n === 1'b0) n++;
    end
    check("pulse", n, `TKS_IRQ_PULSE_NS / `TKS_CLK_NS);
    wr(8'h0A, 8'h04);
    wr(8'h08, 8'h01);
    $display("test irq finished");
    // divider per code, restarted by a warm reset each time
    for (int c = 0; c < 8; c++) begin
      wr(8'h04, {c[2:0], 5'h08});
      wr(8'h03, 8'h04);
      n = 0;
      for (int k = 0; k < 36; k++) begin
        src_tick = (k < 32);
        tk(1);
        if (sensor_tick === 1'b1) n++;
      end
      check("div", n, 32 >> (c > 4 ? 4 : c));
    end
    rchk(8'h04, 8'hE8);
    check("warm_pulses", n_warm, 8);
    check("gates", {gpio_off, fifo_off, touch_off}, 3'h0);
    $display("test sensor finished");
    // pins drive their output state only while general purpose and set as outputs
    wr(8'h16, 8'h07);
    wr(8'h14, 8'h07);
    wr(8'h12, 8'h05);
    check("drive", {gpio_o, gpio_oe_n, touch_sel}, 9'h140);
    wr(8'h12, 8'h02);
    wr(8'h14, 8'h03);
    wr(8'h16, 8'h06);
    check("mixed", {gpio_o, gpio_oe_n, touch_sel}, 9'h0A9);
    // pin change on a masked pin, then on an enabled one
    wr(8'h14, 8'h00);
    wr(8'h16, 8'h07);
    wr(8'h0B, 8'h02);
    wr(8'h09, 8'h80);
    wr(8'h0D, 8'h07);
    wr(8'h0A, 8'hFF);
    gpio_in[0] = 1'b0;
    tk(8);
    rchk(8'h0D, 8'h01);
    rchk(8'h0A, 8'h00);
    check("pin_mask", irq_oe_n, 1'b1);
    gpio_in[1] = 1'b1;
    tk(8);
    rchk(8'h0D, 8'h03);
    rchk(8'h0A, 8'h80);
    check("pin_irq", irq_oe_n, 1'b0);
    wr(8'h0D, 8'h03);
    rchk(8'h0D, 8'h00);
    rchk(8'h10, 8'h06);
    $display("test pins finished");
    // sleep then hibernate, held off by a touched key
    for (int k = 0; k < 2; k++) begin
      m = k ? 8'h01 : 8'h08;
      touch_held = 1'b1;
      wr(8'h03, m);
      check("held", {sleep_req, hib_req}, 2'h0);
      rchk(8'h03, m);
      touch_held = 1'b0;
      tk(2);
      check("req", {sleep_req, hib_req}, k ? 2'h1 : 2'h2);
      {sleep_ack, hib_ack} = k ? 2'h1 : 2'h2;
      tk(1);
      {sleep_ack, hib_ack} = 2'h0;
      tk(3);
      rchk(8'h03, 8'h00);
    end
    $display("test power finished");
    // full reset brings back reset values
    wr(8'h14, 8'h07);
    wr(8'h03, 8'h02);
    rchk(8'h14, 8'h00);
    rchk(8'h04, 8'hEF);
    rchk(8'h0A, 8'h01);
    rchk(8'h03, 8'h00);
    check("soft_pulses", n_soft, 1);
    // foreign address is not answered; reset writes abort their own ack
    tks_host_bfm_i.nak_cnt = 0;
    tks_host_bfm_i.start();
    tks_host_bfm_i.put(8'hA0);
    tks_host_bfm_i.stop();
    rchk(8'h01, 8'h3C);
    check("nak", tks_host_bfm_i.nak_cnt, 1);
    $display("test reset_bus finished");
    test_done();
  end
endmodule : touch_key_system_irq_gpio_tb_top
`default_nettype wire
